// ---- rsff_pkg.sv ----
// How it works
// - Register port is SPI slave, mode zero
// - Sample MOSI on rise, drive MISO on fall
// - MISO released while chip select high
// - Command byte: write bit, 7-bit address
// - Data bytes follow, MSB first
// - Burst address increments after each byte
// - Queue address stays fixed, each byte queued outside receive mode
// - Write frame returns register's previous value
// - Queue holds 66 single-byte entries
// - Shift register serializes and assembles queue bytes
// - Not-empty flag, tracks queue, held during queue read frame
// - Full flag exactly when all entries occupied
// - Sticky overrun; write-one clears and empties
// - Transmit done after last shifted bit
// - Threshold flag updates only on queue access
// - Threshold invalid after full until emptied
// - Queue emptied on listed mode changes
// - Continuous pattern compare sets match flag
// - First bit against first byte MSB
// - Match cleared leaving receive or emptying
// - Pattern 1-8 bytes, 0-7 errors, sent too
package rsff_pkg;

   localparam int         BYTE_W      = 8;
   localparam int         QUEUE_DEPTH = 66;
   localparam int         PAT_BITS    = 64;
   localparam logic [6:0] QUEUE_ADDR  = 7'h00;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [3:0] TX_BITS     = 4'h8;
   localparam logic [6:0] HIST_MAX    = 7'h40;

   // Operating mode of the radio, driven by the control block
   typedef enum logic [2:0] {
      MODE_SLEEP,
      MODE_STDBY,
      MODE_FS,
      MODE_TX,
      MODE_RX
   } rsff_mode_t;

   // Pattern recognition setup; length holds byte count minus one
   typedef struct packed {
      logic        enable;
      logic [2:0]  length;
      logic [2:0]  tolerance;
      logic [63:0] value;
   } rsff_pattern_t;

   // Register file access produced by the SPI slave
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } rsff_regio_t;

endpackage

// ---- rsff_spi_master.sv ----
`timescale 1ns/1ns

// Behavioural SPI master, mode zero, one frame per start request
module rsff_spi_master #(
   parameter int HALF = 10
) (
   input  wire logic        ref_clk,
   input  wire logic        start,
   input  wire logic [2:0]  nbytes,
   input  wire logic [31:0] tx_bytes,
   output logic [31:0]      rx_bytes,
   output logic             done,
   output logic             spi_sck,
   output logic             spi_nss_n,
   output logic             spi_mosi,
   input  wire logic        spi_miso
);
   // Idle levels: clock parked low, select high
   initial begin
      rx_bytes  = 32'h0000_0000;
      done      = 1'b0;
      spi_sck   = 1'b0;
      spi_nss_n = 1'b1;
      spi_mosi  = 1'b0;
   end

   // Frame engine: select, whole bytes MSB first, release
   always begin
      @(posedge ref_clk);
      if (start === 1'b1) begin
         rx_bytes  <= 32'h0000_0000;
         spi_nss_n <= 1'b0;
         for (int i = 0; i < int'(nbytes); i++) begin
            for (int b = 7; b >= 0; b--) begin
               spi_mosi <= tx_bytes[24 - 8 * i + b];
               repeat (HALF) @(posedge ref_clk);
               rx_bytes[24 - 8 * i + b] <= spi_miso;
               spi_sck <= 1'b1;
               repeat (HALF) @(posedge ref_clk);
               spi_sck <= 1'b0;
            end
         end
         repeat (HALF) @(posedge ref_clk);
         spi_nss_n <= 1'b1;
         spi_mosi  <= ~spi_mosi;                               // Released line shows no stale bit
         done      <= 1'b1;
         @(posedge ref_clk);
         done      <= 1'b0;
         repeat (HALF) @(posedge ref_clk);
      end
   end
endmodule // rsff_spi_master

// ---- rsff_top.sv ----
`timescale 1ns/1ns

// Byte queue with show-ahead output
module rsff_queue #(
   parameter int W = 8,
   parameter int D = 66
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   flush,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [W-1:0]           in_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [W-1:0]                out_data,
   output logic [$clog2(D+1)-1:0]      count
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D+1);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } rsff_qst_t;

   rsff_qst_t     q_reg;
   rsff_qst_t     q_next;
   logic [W-1:0]  mem [D];
   logic          push;
   logic          pop;

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      return (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   // Handshake terms and head of queue
   assign in_ready  = (q_reg.cnt != CW'(D));
   assign out_valid = (q_reg.cnt != '0);
   assign out_data  = mem[q_reg.rp];
   assign count     = q_reg.cnt;
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   // Pointer and level update
   always_comb begin
      q_next = q_reg;
      if (flush) begin
         q_next = '0;
      end else begin
         if (push) begin
            q_next.wp = wrap(q_reg.wp);
         end
         if (pop) begin
            q_next.rp = wrap(q_reg.rp);
         end
         q_next.cnt = q_reg.cnt + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[q_reg.wp] <= in_data;
      end
   end

   AST_QUEUE_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      push && !pop |=> q_reg.cnt == $past(q_reg.cnt) + 1'b1)
      else $error("queue level did not grow on push");

endmodule // rsff_queue

module rsff_top
   import rsff_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   input  wire logic          spi_sck,
   input  wire logic          spi_nss_n,
   input  wire logic          spi_mosi,
   output logic               spi_miso_o,
   output logic               spi_miso_oe_n,
   output rsff_regio_t        reg_out,
   input  wire logic [7:0]    reg_rdata,
   input  rsff_mode_t         mode,
   input  rsff_pattern_t      pattern,
   input  wire logic [6:0]    queue_threshold_value,
   input  wire logic          overflow_clear,
   input  wire logic          bit_tick,
   input  wire logic          serial_bit_in,
   output logic               serial_bit_pin,
   output logic               queue_has_data_flag,
   output logic               queue_all_occupied_flag,
   output logic               queue_overflow_sticky,
   output logic               transmit_done_flag,
   output logic               queue_threshold_flag,
   output logic               pattern_match_flag
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [2:0]  sck_s;
      logic [2:0]  nss_s;
      logic [2:0]  mosi_s;
      logic        sck_f;
      logic        nss_f;
      logic        mosi_f;
      logic        in_cmd;
      logic        wr;
      logic        frdq;
      logic [2:0]  bcnt;
      logic [6:0]  addr;
      logic [7:0]  shin;
      logic [7:0]  shout;
      logic        miso;
      logic        ld;
      logic        ld2;
      rsff_regio_t rio;
      rsff_mode_t  mode_prev;
      logic        ne;
      logic        lvl;
      logic        linv;
      logic        qev;
      logic        ovr;
      logic        txd;
      logic        txbit;
      logic [7:0]  tsr;
      logic [3:0]  tcnt;
      logic [63:0] psr;
      logic [6:0]  pcnt;
      logic [7:0]  rsr;
      logic [2:0]  rcnt;
      logic [63:0] hist;
      logic [6:0]  hcnt;
      logic        match;
   } rsff_st_t;

   logic [1:0]    rst_pipe;
   logic          rst_n;
   rsff_st_t      q;
   rsff_st_t      d;
   logic          sck_rise;
   logic          sck_fall;
   logic          nss_fall;
   logic          nss_rise;
   logic [7:0]    rx_byte;
   logic          host_push;
   logic          host_pop;
   logic          sr_push;
   logic          sr_pop;
   logic          q_in_valid;
   logic          q_in_ready;
   logic [7:0]    q_in_data;
   logic          q_valid;
   logic          q_out_ready;
   logic [7:0]    q_data;
   logic [CW-1:0] q_count;
   logic          flush;
   logic          clr_mode;
   logic          q_popped;
   logic [6:0]    nbits;
   logic [63:0]   mask;
   logic [63:0]   diff;
   logic          match_hit;

   function automatic logic [6:0] ones(input logic [63:0] v);
      logic [6:0] n;
      n = '0;
      for (int i = 0; i < PAT_BITS; i++) begin
         n = n + 7'(v[i]);
      end
      return n;
   endfunction

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Pin edges once second and third stages agree
   assign sck_rise = (q.sck_s[1] == q.sck_s[2]) && q.sck_s[2] && !q.sck_f;
   assign sck_fall = (q.sck_s[1] == q.sck_s[2]) && !q.sck_s[2] && q.sck_f;
   assign nss_fall = (q.nss_s[1] == q.nss_s[2]) && !q.nss_s[2] && q.nss_f;
   assign nss_rise = (q.nss_s[1] == q.nss_s[2]) && q.nss_s[2] && !q.nss_f;
   assign rx_byte  = {q.shin[6:0], q.mosi_f};

   // Mode change clearing and pattern window
   assign clr_mode = (mode != q.mode_prev) &&
                     ((mode == MODE_RX && q.mode_prev != MODE_TX) ||
                      (q.mode_prev == MODE_RX && mode == MODE_TX) ||
                      q.mode_prev == MODE_TX);
   assign flush     = clr_mode || overflow_clear;
   assign nbits     = {4'(({1'b0, pattern.length}) + 4'h1), 3'h0};
   assign mask      = ~64'h0 << (HIST_MAX - nbits);
   assign diff      = ((q.hist << (HIST_MAX - nbits)) ^ pattern.value) & mask;
   assign match_hit = pattern.enable && mode == MODE_RX && q.hcnt >= nbits &&
                      ones(diff) <= {4'h0, pattern.tolerance};

   // Queue port sharing between host and shift register
   assign q_in_valid  = host_push || sr_push;
   assign q_in_data   = sr_push ? {q.rsr[6:0], serial_bit_in} : rx_byte;
   assign q_out_ready = host_pop || sr_pop;
   assign q_popped    = q_out_ready && q_valid && !flush;

   always_comb begin
      d         = q;
      host_push = 1'b0;
      host_pop  = 1'b0;
      sr_push   = 1'b0;
      sr_pop    = 1'b0;
      // Three-stage pin capture
      d.sck_s  = {q.sck_s[1:0], spi_sck};
      d.nss_s  = {q.nss_s[1:0], spi_nss_n};
      d.mosi_s = {q.mosi_s[1:0], spi_mosi};
      if (q.sck_s[1] == q.sck_s[2]) begin
         d.sck_f = q.sck_s[2];
      end
      if (q.nss_s[1] == q.nss_s[2]) begin
         d.nss_f = q.nss_s[2];
      end
      if (q.mosi_s[1] == q.mosi_s[2]) begin
         d.mosi_f = q.mosi_s[2];
      end
      d.rio.wr    = 1'b0;
      d.ld        = 1'b0;
      d.ld2       = q.ld;
      d.qev       = 1'b0;
      d.mode_prev = mode;
      // Frame start and not-empty refresh
      if (nss_fall) begin
         d.in_cmd = 1'b1;
         d.bcnt   = 3'h0;
         d.miso   = 1'b0;
         d.shout  = 8'h00;
         d.ne     = q_valid;
      end else if (!q.frdq) begin
         d.ne = q_valid;
      end
      if (nss_rise) begin
         d.frdq = 1'b0;
      end
      // Sample MOSI on rising clock
      if (sck_rise && !q.nss_f) begin
         d.shin = rx_byte;
         d.bcnt = q.bcnt + 3'h1;
         if (q.bcnt == BIT_LAST) begin
            d.ld = 1'b1;
            if (q.in_cmd) begin
               d.in_cmd = 1'b0;
               d.wr     = q.shin[6];
               d.addr   = rx_byte[6:0];
               d.frdq   = !q.shin[6] && rx_byte[6:0] == QUEUE_ADDR;
            end else begin
               if (q.wr && q.addr == QUEUE_ADDR) begin
                  host_push = (mode != MODE_RX);
               end else if (q.wr) begin
                  d.rio.wr    = 1'b1;
                  d.rio.addr  = q.addr;
                  d.rio.wdata = rx_byte;
               end else if (q.addr == QUEUE_ADDR) begin
                  host_pop = (mode != MODE_TX); // Pop only a byte fully shifted out
               end
               if (q.addr != QUEUE_ADDR) begin
                  d.addr = q.addr + 7'h01;
               end
            end
         end
      end
      // Fetch next byte to return, after any write
      if (q.ld) begin
         d.rio.addr = q.addr;
      end
      if (q.ld2) begin
         if (q.addr == QUEUE_ADDR) begin
            d.shout = q_valid ? q_data : 8'h00; // Peek at head, no pop yet
         end else begin
            d.shout = reg_rdata;
         end
      end
      // Drive MISO on falling clock
      if (sck_fall && !q.nss_f && !q.in_cmd) begin
         d.miso  = q.shout[7];
         d.shout = {q.shout[6:0], 1'b0};
      end
      // Transmit path: pattern first, then queued bytes
      if (mode == MODE_TX && q.mode_prev != MODE_TX) begin
         d.psr  = pattern.value;
         d.pcnt = pattern.enable ? nbits : 7'h00;
         d.tcnt = 4'h0;
         d.txd  = 1'b0;
      end else if (mode == MODE_TX && bit_tick) begin
         if (q.pcnt != 7'h00) begin
            d.txbit = q.psr[63];
            d.psr   = {q.psr[62:0], 1'b0};
            d.pcnt  = q.pcnt - 7'h01;
         end else if (q.tcnt != 4'h0) begin
            d.txbit = q.tsr[7];
            d.tsr   = {q.tsr[6:0], 1'b0};
            d.tcnt  = q.tcnt - 4'h1;
            if (q.tcnt == 4'h1 && !q_valid) begin
               d.txd = 1'b1;
            end
         end else if (q_valid) begin
            sr_pop  = 1'b1;
            d.txbit = q_data[7];
            d.tsr   = {q_data[6:0], 1'b0};
            d.tcnt  = TX_BITS - 4'h1;
         end
      end
      // Receive path: history for matching, byte assembly
      if (mode == MODE_RX && q.mode_prev != MODE_RX) begin
         d.hcnt = 7'h00;
         d.rcnt = 3'h0;
      end else if (mode == MODE_RX && bit_tick) begin
         d.hist = {q.hist[62:0], serial_bit_in};
         if (q.hcnt != HIST_MAX) begin
            d.hcnt = q.hcnt + 7'h01;
         end
         if (!pattern.enable || q.match) begin
            d.rsr  = {q.rsr[6:0], serial_bit_in};
            d.rcnt = q.rcnt + 3'h1;
            sr_push = (q.rcnt == BIT_LAST);
         end
      end
      // Pattern match flag, set wins over clear
      if ((q.mode_prev == MODE_RX && mode != MODE_RX) || flush ||
          (q_popped && !q_in_valid && q_count == CW'(1))) begin
         d.match = 1'b0;
      end
      if (match_hit) begin
         if (!q.match) begin
            d.rcnt = 3'h0;
         end
         d.match = 1'b1;
      end
      // Overrun sticky, set wins over write-one clear
      if (overflow_clear) begin
         d.ovr = 1'b0;
      end
      if (q_in_valid && !q_in_ready) begin
         d.ovr = 1'b1;
      end
      // Threshold flag, forced low from full until empty
      d.qev = (q_in_valid && q_in_ready && !flush) || q_popped;
      if (q_count == CW'(DEPTH)) begin
         d.linv = 1'b1;
      end else if (q_count == '0) begin
         d.linv = 1'b0;
      end
      if (q.qev) begin
         d.lvl = !d.linv && (q_count > CW'(queue_threshold_value));
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.nss_s <= 3'h7;
         q.nss_f <= 1'b1;
      end else begin
         q <= d;
      end
   end

   rsff_queue #(.W(BYTE_W), .D(DEPTH)) u_queue (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .flush     (flush),
      .in_valid  (q_in_valid),
      .in_ready  (q_in_ready),
      .in_data   (q_in_data),
      .out_valid (q_valid),
      .out_ready (q_out_ready),
      .out_data  (q_data),
      .count     (q_count)
   );

   // Outputs
   assign spi_miso_o              = q.miso;
   assign spi_miso_oe_n           = q.nss_f;
   assign reg_out                 = q.rio;
   assign serial_bit_pin          = q.txbit;
   assign queue_has_data_flag     = q.ne;
   assign queue_all_occupied_flag = !q_in_ready;
   assign queue_overflow_sticky   = q.ovr;
   assign transmit_done_flag      = q.txd;
   assign queue_threshold_flag    = q.lvl;
   assign pattern_match_flag      = q.match;

   AST_MISO_HIZ: assert property (@(posedge ref_clk) disable iff (!rst_n)
      spi_nss_n [*6] |-> spi_miso_oe_n)
      else $error("MISO driven while chip select high");
   AST_CMD_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sck_rise && !q.nss_f && q.in_cmd && q.bcnt == BIT_LAST |=> q.wr == $past(q.shin[6]))
      else $error("command direction bit not taken");
   AST_ADDR_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sck_rise && !q.nss_f && !q.in_cmd && q.bcnt == BIT_LAST && q.addr != QUEUE_ADDR
      |=> q.addr == $past(q.addr) + 7'h01)
      else $error("burst address did not increment");
   AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !q.in_cmd && q.addr == QUEUE_ADDR && !nss_fall |=> q.addr == QUEUE_ADDR)
      else $error("queue address moved");
   AST_WR_BEFORE_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_out.wr |=> q.ld2 && !reg_out.wr)
      else $error("next value fetched out of order with write");
   AST_OVR_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_in_valid && queue_all_occupied_flag |=> queue_overflow_sticky)
      else $error("overrun not flagged");
   AST_MODE_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q.mode_prev == MODE_RX && mode == MODE_TX |=> q_count == '0)
      else $error("queue not emptied from receive to transmit");
   AST_MATCH_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q.mode_prev == MODE_RX && mode != MODE_RX |=> !pattern_match_flag)
      else $error("match flag kept after leaving receive");
   AST_LVL_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !q.qev |=> $stable(queue_threshold_flag))
      else $error("threshold flag moved without queue access");
   AST_TX_MSB: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sr_pop |=> serial_bit_pin == $past(q_data[7]) && q.tcnt == 4'h7)
      else $error("transmit byte not sent MSB first");
   AST_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(transmit_done_flag) |-> $past(bit_tick) && $past(q.tcnt) == 4'h1)
      else $error("transmit done raised before last bit");

endmodule // rsff_top

// ---- test_rsff_top.sv ----
`timescale 1ns/1ns

// Self-checking bench for the SPI and queue front end
module test_rsff_top
   import rsff_pkg::*;
;
   localparam int LIMIT = 60000;
   logic          ref_clk;
   logic          arst_n;
   logic          spi_sck;
   logic          spi_nss_n;
   logic          spi_mosi;
   logic          spi_miso_o;
   logic          spi_miso_oe_n;
   logic          miso_w;
   logic          miso_last;
   rsff_regio_t   reg_out;
   logic [7:0]    reg_rdata;
   rsff_mode_t    mode;
   rsff_pattern_t pattern;
   logic [6:0]    queue_threshold_value;
   logic          overflow_clear;
   logic          bit_tick;
   logic          serial_bit_in;
   logic          serial_bit_pin;
   logic          has_flag;
   logic          full_flag;
   logic          ovr_flag;
   logic          done_flag;
   logic          thr_flag;
   logic          match_flag;
   logic          m_start;
   logic [2:0]    m_nbytes;
   logic [31:0]   m_tx;
   logic [31:0]   m_rx;
   logic          m_done;
   logic [31:0]   rx;
   logic [7:0]    regs [128];
   int            failures;
   int            total_checks;
   int            cycles;

   rsff_top uut (
      .ref_clk(ref_clk), .arst_n(arst_n), .spi_sck(spi_sck), .spi_nss_n(spi_nss_n),
      .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n),
      .reg_out(reg_out), .reg_rdata(reg_rdata), .mode(mode), .pattern(pattern),
      .queue_threshold_value(queue_threshold_value), .overflow_clear(overflow_clear),
      .bit_tick(bit_tick), .serial_bit_in(serial_bit_in), .serial_bit_pin(serial_bit_pin),
      .queue_has_data_flag(has_flag), .queue_all_occupied_flag(full_flag),
      .queue_overflow_sticky(ovr_flag), .transmit_done_flag(done_flag),
      .queue_threshold_flag(thr_flag), .pattern_match_flag(match_flag)
   );

   rsff_spi_master u_master (
      .ref_clk(ref_clk), .start(m_start), .nbytes(m_nbytes), .tx_bytes(m_tx), .rx_bytes(m_rx),
      .done(m_done), .spi_sck(spi_sck), .spi_nss_n(spi_nss_n), .spi_mosi(spi_mosi), .spi_miso(miso_w)
   );

   // Released MISO shows the inverse of its last driven bit
   assign miso_w    = spi_miso_oe_n ? ~miso_last : spi_miso_o;
   assign reg_rdata = regs[reg_out.addr];

   function automatic logic [7:0] init_val(input logic [6:0] a);
      return {1'b0, a} ^ 8'hc3;
   endfunction

   // Clock, outside register file, timeout
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (spi_miso_oe_n === 1'b0) miso_last <= spi_miso_o;
      if (reg_out.wr === 1'b1) regs[reg_out.addr] <= reg_out.wdata;
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One SPI frame through the master model, bounded wait
   task automatic frame(input logic [2:0] n, input logic [31:0] b);
      int k;
      k = 0;
      @(posedge ref_clk);
      m_nbytes <= n;
      m_tx     <= b;
      m_start  <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (m_done !== 1'b1 && k < 4000);
      if (k >= 4000) failures++;
      rx = m_rx;
      m_start <= 1'b0;
   endtask

   task automatic set_mode(input rsff_mode_t m);
      @(posedge ref_clk);
      mode <= m;
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic tick(input logic b);
      @(posedge ref_clk);
      bit_tick      <= 1'b1;
      serial_bit_in <= b;
      @(posedge ref_clk);
      bit_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic test_burst();
      frame(3'h3, 32'h85a1_b200);
      check("old reg5", 16'(rx[23:16]), 16'(init_val(7'h05)));
      check("old reg6", 16'(rx[15:8]), 16'(init_val(7'h06)));
      check("reg5", 16'(regs[5]), 16'h00a1);
      check("reg6", 16'(regs[6]), 16'h00b2);
      frame(3'h3, 32'h0500_0000);
      check("burst read", rx[23:8], 16'ha1b2);
      repeat (6) @(posedge ref_clk);
      check("miso released", 16'(spi_miso_oe_n), 16'h1);
      $display("test burst done");
   endtask

   task automatic test_queue();
      frame(3'h4, 32'h8011_2233);
      check("has data", 16'(has_flag), 16'h1);
      frame(3'h4, 32'h0000_0000);
      check("queue head", rx[23:8], 16'h1122);
      check("queue tail", 16'(rx[7:0]), 16'h0033);
      frame(3'h2, 32'h0500_0000);
      check("drained", 16'(has_flag), 16'h0);
      $display("test queue done");
   endtask

   task automatic test_fill();
      frame(3'h4, 32'h8001_0203);
      check("thr low", 16'(thr_flag), 16'h0);
      @(posedge ref_clk);
      queue_threshold_value <= 7'h02;
      repeat (4) @(posedge ref_clk);
      check("thr hold", 16'(thr_flag), 16'h0);
      for (int i = 1; i < QUEUE_DEPTH / 3; i++) begin
         frame(3'h4, 32'h8000_0000 + i);
         if (i == 1) check("thr high", 16'(thr_flag), 16'h1);
         if (i == QUEUE_DEPTH / 3 - 2) check("not yet full", 16'(full_flag), 16'h0);
      end
      check("full", 16'(full_flag), 16'h1);
      check("thr invalid", 16'(thr_flag), 16'h0);
      frame(3'h2, 32'h80ee_0000);
      check("overrun", 16'(ovr_flag), 16'h1);
      check("still full", 16'(full_flag), 16'h1);
      @(posedge ref_clk);
      overflow_clear <= 1'b1;
      @(posedge ref_clk);
      overflow_clear <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("overrun clr", 16'(ovr_flag), 16'h0);
      check("emptied", 16'(has_flag), 16'h0);
      check("not full", 16'(full_flag), 16'h0);
      frame(3'h4, 32'h8001_0203);
      check("thr back", 16'(thr_flag), 16'h1);
      $display("test fill done");
   endtask

   task automatic test_modes();
      set_mode(MODE_SLEEP);
      check("stdby to sleep", 16'(has_flag), 16'h1);
      set_mode(MODE_STDBY);
      check("sleep to stdby", 16'(has_flag), 16'h1);
      set_mode(MODE_RX);
      check("into rx", 16'(has_flag), 16'h0);
      set_mode(MODE_STDBY);
      $display("test modes done");
   endtask

   task automatic test_tx();
      logic [15:0] bits;
      bits = 16'h0000;
      @(posedge ref_clk);
      pattern <= {1'b1, 3'h0, 3'h0, 8'ha5, 56'h0};
      frame(3'h2, 32'h803c_0000);
      set_mode(MODE_TX);
      check("done clr", 16'(done_flag), 16'h0);
      check("kept into tx", 16'(has_flag), 16'h1);
      for (int i = 0; i < 16; i++) begin
         tick(1'b0);
         bits = {bits[14:0], serial_bit_pin};
      end
      check("tx bits", bits, 16'ha53c);
      check("sent", 16'(done_flag), 16'h1);
      frame(3'h2, 32'h8077_0000);
      set_mode(MODE_STDBY);
      check("leave tx", 16'(has_flag), 16'h0);
      $display("test tx done");
   endtask

   task automatic rx_case(input logic [2:0] len, input logic [2:0] tol, input logic [15:0] pat,
                          input logic [15:0] err);
      int n;
      n = 8 * (int'(len) + 1);
      @(posedge ref_clk);
      pattern <= {1'b1, len, tol, pat, 48'h0};
      for (int i = 0; i < 8; i++) tick(1'b0);
      for (int i = 15; i > 16 - n; i--) tick(pat[i] ^ err[i]);
      check("no early match", 16'(match_flag), 16'h0);
      tick(pat[16 - n] ^ err[16 - n]);
      check("match", 16'(match_flag), 16'h1);
   endtask

   task automatic test_rx();
      set_mode(MODE_RX);
      rx_case(3'h0, 3'h0, 16'ha500, 16'h0000);
      for (int i = 15; i >= 0; i--) tick(logic'(16'h5ac3 >> i));
      frame(3'h2, 32'h0000_0000);
      check("rx byte", 16'(rx[23:16]), 16'h005a);
      set_mode(MODE_TX);
      check("rx to tx", 16'(has_flag), 16'h0);
      check("done reclr", 16'(done_flag), 16'h0);
      check("match gone", 16'(match_flag), 16'h0);
      set_mode(MODE_STDBY);
      set_mode(MODE_RX);
      rx_case(3'h1, 3'h1, 16'h1234, 16'h0100);
      set_mode(MODE_STDBY);
      check("left rx", 16'(match_flag), 16'h0);
      $display("test rx done");
   endtask

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      arst_n = 1'b0;
      mode = MODE_STDBY;
      pattern = '0;
      queue_threshold_value = 7'h05;
      overflow_clear = 1'b0;
      bit_tick = 1'b0;
      serial_bit_in = 1'b0;
      miso_last = 1'b0;
      m_start = 1'b0;
      m_nbytes = 3'h0;
      m_tx = 32'h0000_0000;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      for (int i = 0; i < 128; i++) regs[i] = init_val(7'(i));
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
      test_burst();
      test_queue();
      test_fill();
      test_modes();
      test_tx();
      test_rx();
      give_verdict();
   end
endmodule // test_rsff_top
